// ---- ssp_pkg.sv ----
// Constants and types shared by the serial shift port design.
// Summary of operation
// - Shift register and bit counter move only on shift clock falls.
// - Eight-bit shift register, serial in to serial out; four-bit counter.
// - Data shifts most significant bit first in both directions.
// - After eight clocks the terminal output goes low and freezes shifting.
// - Interrupt fires on eighth fall unless a disable write came first.
// - After reset the transfer interrupt is off until data is written.
// - Writing the data register loads data and arms the interrupt.
// - Any write to the disable register disarms the interrupt.
// - Reset and data writes clear the counter and re-enable the clock.
// - No start condition; shifting starts at the first edge after clearing.
// - Interrupt request is signalled as a high-to-low transition.
// - In open-drain mode the serial out pin carries the shift register msb; otherwise the port bit.
package ssp_pkg;

    localparam int         SSP_DATA_W     = 8;
    localparam int         SSP_CNT_W      = 4;
    localparam int         SSP_ADDR_W     = 12;
    // Printed register indices; byte address is four times the index
    localparam logic [7:0] SSP_IDX_IRQDIS = 8'hdc;
    localparam logic [7:0] SSP_IDX_SHIFT  = 8'hdd;
    localparam logic [SSP_ADDR_W-1:0] SSP_A_IRQDIS =
        {2'h0, SSP_IDX_IRQDIS, 2'h0};
    localparam logic [SSP_ADDR_W-1:0] SSP_A_SHIFT  =
        {2'h0, SSP_IDX_SHIFT, 2'h0};
    localparam logic [SSP_ADDR_W-1:0] SSP_A_STATUS = 12'h380;
    localparam logic [SSP_ADDR_W-1:0] SSP_A_MASK   = 12'h384;
    localparam logic [SSP_ADDR_W-1:0] SSP_A_CTRL   = 12'h388;

    // Field positions
    localparam int SSP_STS_DONE   = 0;
    localparam int SSP_CTRL_OD    = 0;
    localparam int SSP_CTRL_PORT  = 1;
    localparam int SSP_IRQDIS_ARM = 0;

    localparam logic [SSP_CNT_W-1:0]  SSP_CNT_FULL  = 4'h8;
    localparam logic [SSP_CNT_W-1:0]  SSP_CNT_RST   = 4'h0;
    localparam logic [SSP_DATA_W-1:0] SSP_DATA_RST  = 8'h00;
    localparam logic [1:0]            SSP_CTRL_RST  = 2'h2;

    typedef struct packed {
        logic s1;
        logic s2;
        logic d1;
        logic d2;
        logic prev;
    } ssp_sync_t;

    typedef struct packed {
        logic [SSP_DATA_W-1:0] shift;
        logic [SSP_CNT_W-1:0]  cnt;
        logic                  armed;
        logic                  irq_n;
        logic                  sts;
        logic                  mask;
        logic [1:0]            ctrl;
        logic [31:0]           prdata;
    } ssp_state_t;

endpackage : ssp_pkg

// ---- ssp_link_if.sv ----
// Carrier between the pin synchroniser and the shift port core.
`timescale 1ns/1ps
`default_nettype none
interface ssp_link_if;
    logic sclk_fall;
    logic sin;
    modport src (output sclk_fall, output sin);
    modport dst (input sclk_fall, input sin);
endinterface : ssp_link_if
`default_nettype wire

// ---- ssp_sync.sv ----
// Pin synchroniser and shift clock falling edge detector.
`timescale 1ns/1ps
`default_nettype none
module ssp_sync
    import ssp_pkg::*;
(
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_sclk,
    input  wire logic i_sin,
    ssp_link_if.src   link
);
    ssp_sync_t st_r;
    ssp_sync_t st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.s1   = i_sclk;
        st_nxt.s2   = st_r.s1;
        st_nxt.d1   = i_sin;
        st_nxt.d2   = st_r.d1;
        st_nxt.prev = st_r.s2;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // Idle clock high so release is not seen as an edge
            st_r <= '{s1: 1'b1, s2: 1'b1, d1: 1'b0, d2: 1'b0, prev: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.sclk_fall = st_r.prev & ~st_r.s2;
    assign link.sin       = st_r.d2;
endmodule : ssp_sync
`default_nettype wire

// ---- ssp_top.sv ----
// Serial shift port with bit counter, APB register slave and interrupt.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ssp_top
    import ssp_pkg::*;
(
    input  wire logic                  i_clock,
    input  wire logic                  i_nrst,
    // APB slave
    input  wire logic                  i_psel,
    input  wire logic                  i_penable,
    input  wire logic                  i_pwrite,
    input  wire logic [SSP_ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]           i_pwdata,
    output logic [31:0]                o_prdata,
    output logic                       o_pready,
    output logic                       o_pslverr,
    // Serial pins
    input  wire logic                  i_sclk,
    input  wire logic                  i_sin,
    output logic                       o_sout,
    output logic                       o_sout_oe,
    // Interrupts and count terminal
    output logic                       o_xfer_irq_n,
    output logic                       o_irq,
    output logic                       o_count_terminal_out
);
    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_s1_r;
    logic rst_n_r;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    ssp_link_if link ();

    ssp_sync u_sync (
        .i_clock (i_clock),
        .i_rst_n (rst_n_r),
        .i_sclk  (i_sclk),
        .i_sin   (i_sin),
        .link    (link.src)
    );

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic [5:0] addr_dec(
        input logic [SSP_ADDR_W-1:0] a
    );
        addr_dec = {a == SSP_A_CTRL,
                    a == SSP_A_MASK,
                    a == SSP_A_STATUS,
                    a == SSP_A_SHIFT,
                    a == SSP_A_IRQDIS,
                    1'b0};
        addr_dec[0] = ~|addr_dec[5:1];
    endfunction : addr_dec

    ssp_state_t st_r;
    ssp_state_t st_nxt;
    logic [5:0] hit;
    logic       setup;
    logic       wr;
    logic       running;
    logic       done_evt;

    assign hit     = addr_dec(i_paddr);
    assign setup   = i_psel & ~i_penable;
    assign wr      = i_psel & i_penable & i_pwrite;
    // terminal output low at count eight
    assign running = st_r.cnt != SSP_CNT_FULL;
    assign done_evt = link.sclk_fall & running
                    & (st_r.cnt == SSP_CNT_FULL - 4'h1);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;

        if (link.sclk_fall && running) begin
            // msb out first, new bit at lsb
            st_nxt.shift = {st_r.shift[SSP_DATA_W-2:0], link.sin};
            st_nxt.cnt   = st_r.cnt + 4'h1;
        end

        // fire on eighth edge if armed
        if (done_evt && st_r.armed) begin
            st_nxt.irq_n = 1'b0;
        end

        // Status clear by writing one; new event set wins
        if (wr && hit[3] && i_pwdata[SSP_STS_DONE]) begin
            st_nxt.sts = 1'b0;
        end
        if (done_evt) begin
            st_nxt.sts = 1'b1;
        end

        if (wr && hit[4]) begin
            st_nxt.mask = i_pwdata[SSP_STS_DONE];
        end
        if (wr && hit[5]) begin
            st_nxt.ctrl = i_pwdata[1:0];
        end

        if (wr && hit[1]) begin
            st_nxt.armed = 1'b0;
            st_nxt.irq_n = 1'b1;
        end

        // Data write beats a same-cycle edge
        if (wr && hit[2]) begin
            st_nxt.shift = i_pwdata[SSP_DATA_W-1:0];
            st_nxt.cnt   = SSP_CNT_RST;
            st_nxt.armed = 1'b1;
            st_nxt.irq_n = 1'b1;
        end

        // Read data captured in setup, shown in access
        if (setup && !i_pwrite) begin
            unique case (1'b1)
                hit[1]:  st_nxt.prdata = {31'h0, st_r.armed};
                hit[2]:  st_nxt.prdata = {24'h0, st_r.shift};
                hit[3]:  st_nxt.prdata = {31'h0, st_r.sts};
                hit[4]:  st_nxt.prdata = {31'h0, st_r.mask};
                hit[5]:  st_nxt.prdata = {30'h0, st_r.ctrl};
                default: st_nxt.prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r <= '{shift:  SSP_DATA_RST,
                      cnt:    SSP_CNT_RST,
                      armed:  1'b0,
                      irq_n:  1'b1,
                      sts:    1'b0,
                      mask:   1'b0,
                      ctrl:   SSP_CTRL_RST,
                      prdata: 32'h0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_prdata  = st_r.prdata;
    // Zero wait state; unmapped answers with an error
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel & i_penable & hit[0];

    // serial out from shift register msb in open-drain mode, else the port bit
    always_comb begin
        if (st_r.ctrl[SSP_CTRL_OD]) begin
            o_sout    = 1'b0;
            o_sout_oe = ~st_r.shift[SSP_DATA_W-1];
        end else begin
            o_sout    = st_r.ctrl[SSP_CTRL_PORT];
            o_sout_oe = 1'b1;
        end
    end

    assign o_xfer_irq_n         = st_r.irq_n;
    assign o_irq                = st_r.sts & st_r.mask;
    assign o_count_terminal_out = running;
endmodule : ssp_top
`default_nettype wire

// ---- ssp_assertions.sv ----
// Port checks of the serial shift port.
`timescale 1ns/1ps
`default_nettype none
module ssp_assertions
    import ssp_pkg::*;
(
    input wire logic                  i_clock,
    input wire logic                  i_nrst,
    input wire logic                  i_psel,
    input wire logic                  i_penable,
    input wire logic                  i_pwrite,
    input wire logic [SSP_ADDR_W-1:0] i_paddr,
    input wire logic                  i_sclk,
    input wire logic                  o_sout,
    input wire logic                  o_sout_oe,
    input wire logic                  o_xfer_irq_n,
    input wire logic                  o_count_terminal_out
);
    // ----------
    // Properties
    // ----------
    logic       wsh;
    logic       wdis;
    logic [5:0] sck;
    assign wsh  = i_psel & i_penable & i_pwrite & (i_paddr == SSP_A_SHIFT);
    assign wdis = i_psel & i_penable & i_pwrite & (i_paddr == SSP_A_IRQDIS);
    // Pin history long enough to span the sync latency
    always_ff @(posedge i_clock) sck <= {sck[4:0], i_sclk};
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    property p_src; $fell(o_count_terminal_out) |-> !(&sck); endproperty
    a_src: assert property (p_src)
        else $error("count moved without clock fall");
    property p_frz; !o_count_terminal_out && !wsh |=> !o_count_terminal_out;
    endproperty
    a_frz: assert property (p_frz)
        else $error("frozen counter moved");
    property p_fire; $fell(o_xfer_irq_n) |-> !o_count_terminal_out; endproperty
    a_fire: assert property (p_fire)
        else $error("irq fell before eighth edge");
    property p_arm; wsh |=> o_xfer_irq_n && o_count_terminal_out; endproperty
    a_arm: assert property (p_arm)
        else $error("data write did not restart");
    property p_dis; wdis |=> o_xfer_irq_n; endproperty
    a_dis: assert property (p_dis)
        else $error("disable write kept irq");
    property p_hold; !o_xfer_irq_n && !wsh && !wdis |=> !o_xfer_irq_n;
    endproperty
    a_hold: assert property (p_hold)
        else $error("irq released on its own");
    property p_rst; $rose(o_count_terminal_out) |-> $past(wsh); endproperty
    a_rst: assert property (p_rst)
        else $error("counter cleared without data write");
    property p_od; !o_sout_oe |-> !o_sout; endproperty
    a_od: assert property (p_od)
        else $error("released pin driven high");
    c_fire: cover property ($fell(o_xfer_irq_n));
    c_od:   cover property (!o_sout_oe);
    c_dis:  cover property (wdis);
endmodule : ssp_assertions
bind ssp_top ssp_assertions u_chk (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_sclk(i_sclk), .o_sout(o_sout),
    .o_sout_oe(o_sout_oe), .o_xfer_irq_n(o_xfer_irq_n),
    .o_count_terminal_out(o_count_terminal_out));
`default_nettype wire

// ---- ssp_partner.sv ----
// External serial master model for the shift port.
`timescale 1ns/1ps
`default_nettype none
module ssp_partner (
    output logic      o_sclk,
    output logic      o_sin,
    input  wire logic i_sdat
);
    // -----
    // Frame
    // -----
    initial begin
        o_sclk = 1'b1;
        o_sin  = 1'b0;
    end
    task automatic xfer(input int n, input logic [7:0] tx,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < n; i++) begin
            o_sin = tx[7-i];
            #80;
            rx[7-i] = i_sdat;
            o_sclk = 1'b0;
            #160;
            o_sclk = 1'b1;
            #80;
        end
        // Line no longer held, so stale data must not look valid
        o_sin = ~o_sin;
    endtask : xfer
endmodule : ssp_partner
`default_nettype wire

// ---- test_ssp_top.sv ----
// Self-checking bench of the serial shift port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin error_cnt++; \
 $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x); end end
module test_ssp_top
    import ssp_pkg::*;
;
    // -----
    // Bench
    // -----
    logic                  clk, nrst, psel, pen, pwr, e, sclk, sin, sdat;
    logic [SSP_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata, prdata, q;
    logic                  pready, pslverr, sout, oe, irqn, irq, term;
    logic [7:0]            rx;
    int                    error_cnt = 0, total_checks = 0, cyc = 0;
    assign sdat = oe ? sout : 1'b1;
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    ssp_top dut (.i_clock(clk), .i_nrst(nrst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_sclk(sclk), .i_sin(sin), .o_sout(sout), .o_sout_oe(oe),
        .o_xfer_irq_n(irqn), .o_irq(irq), .o_count_terminal_out(term));
    ssp_partner u_ptr (.o_sclk(sclk), .o_sin(sin), .i_sdat(sdat));
    task automatic apb(input logic w, input logic [SSP_ADDR_W-1:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(negedge clk);
    endtask : apb
    task automatic rd(input logic [SSP_ADDR_W-1:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(q, x)
    endtask : rd
    task automatic sx(input int n, input logic [7:0] t);
        u_ptr.xfer(n, t, rx);
        repeat (2) @(negedge clk);
    endtask : sx
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        {nrst, psel, pen, pwr, paddr, pwdata} = '0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rd(SSP_A_SHIFT, 32'h0);
        rd(SSP_A_IRQDIS, 32'h0);
        `CHK(term, 1'b1)
        `CHK({oe, sout}, 2'h3)
        apb(1'b0, 12'h3fc, 32'h0);
        `CHK(e, 1'b1)
        $display("test reset done");
        sx(8, 8'h96);
        rd(SSP_A_SHIFT, 32'h96);
        `CHK(irqn, 1'b1)
        `CHK(term, 1'b0)
        $display("test unarmed done");
        apb(1'b1, SSP_A_CTRL, 32'h1);
        apb(1'b1, SSP_A_MASK, 32'h1);
        apb(1'b1, SSP_A_STATUS, 32'h1);
        apb(1'b1, SSP_A_SHIFT, 32'ha5);
        rd(SSP_A_IRQDIS, 32'h1);
        sx(8, 8'h3c);
        `CHK(rx, 8'ha5)
        `CHK(irqn, 1'b0)
        `CHK(irq, 1'b1)
        sx(8, 8'hff);
        rd(SSP_A_SHIFT, 32'h3c);
        `CHK(irqn, 1'b0)
        apb(1'b1, SSP_A_IRQDIS, 32'h0);
        `CHK(irqn, 1'b1)
        apb(1'b1, SSP_A_STATUS, 32'h1);
        `CHK(irq, 1'b0)
        $display("test frame done");
        apb(1'b1, SSP_A_SHIFT, 32'h0);
        sx(4, 8'h90);
        apb(1'b1, SSP_A_SHIFT, 32'h0);
        sx(4, 8'h90);
        `CHK(irqn, 1'b1)
        sx(4, 8'h60);
        rd(SSP_A_SHIFT, 32'h96);
        `CHK(irqn, 1'b0)
        $display("test restart done");
        apb(1'b1, SSP_A_MASK, 32'h0);
        apb(1'b1, SSP_A_STATUS, 32'h1);
        rd(SSP_A_STATUS, 32'h0);
        apb(1'b1, SSP_A_SHIFT, 32'h11);
        apb(1'b1, SSP_A_IRQDIS, 32'h55);
        rd(SSP_A_IRQDIS, 32'h0);
        sx(8, 8'h00);
        `CHK(irqn, 1'b1)
        rd(SSP_A_STATUS, 32'h1);
        `CHK(irq, 1'b0)
        apb(1'b1, SSP_A_CTRL, 32'h2);
        `CHK({oe, sout}, 2'h3)
        rd(SSP_A_CTRL, 32'h2);
        $display("test disarm done");
        tally_and_finish();
    end
endmodule : test_ssp_top
`default_nettype wire
